// ---- rtl/rfgc_core.sv ----
// Chosen here: the address map and the strobed register port.
`include "rfgc_defs.svh"

module rfgc_core #(
  parameter int FW = 16,
  parameter int MW = 20
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 rx_active,
  input  wire logic                 sync_det,
  input  wire logic [7:0]           rssi_level,
  input  wire logic                 freq_valid,
  input  wire logic signed [FW-1:0] freq_sample,
  input  wire logic                 amp_valid,
  input  wire logic [3:0]           amp_peak,
  output logic signed [FW-1:0]      slicer_offset,
  output logic signed [FW-1:0]      if2_tune,
  output logic [3:0]                atten_step,
  output logic [5:0]                atten_db,
  output logic                      fc_fast_mode
);
  import rfgc_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic                 fc_en_ff;
  logic                 fc_mode_ff;
  logic                 gc_en_ff;
  logic                 freeze_en_ff;
  rfgc_mod_t            mod_sel_ff;
  logic [3:0]           fast_gain_ff;
  logic [3:0]           slow_gain_ff;
  logic [7:0]           period_ff;
  logic [7:0]           pwr_thr_ff;
  logic [3:0]           hi_thr_ff;
  logic [3:0]           lo_thr0_ff;
  logic [3:0]           lo_thr1_ff;
  logic [7:0]           lo_sel_ff;
  logic [3:0]           meas_exp_ff;
  logic [5:0]           hold_val_ff;
  logic [31:0]          rdata_ff;
  logic [31:0]          nxt_rdata;

  // Software configuration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_en_ff     <= 1'b0;
      fc_mode_ff   <= 1'b0;
      gc_en_ff     <= 1'b0;
      freeze_en_ff <= 1'b0;
      mod_sel_ff   <= MOD_2FSK;
      fast_gain_ff <= `RFGC_RST_FAST_GAIN;
      slow_gain_ff <= `RFGC_RST_SLOW_GAIN;
      period_ff    <= `RFGC_RST_PERIOD;
      pwr_thr_ff   <= `RFGC_RST_PWR_THR;
      hi_thr_ff    <= `RFGC_RST_HI_THR;
      lo_thr0_ff   <= `RFGC_RST_LO_THR0;
      lo_thr1_ff   <= `RFGC_RST_LO_THR1;
      lo_sel_ff    <= `RFGC_RST_LO_SEL;
      meas_exp_ff  <= `RFGC_RST_MEAS_EXP;
      hold_val_ff  <= `RFGC_RST_HOLD;
    end else if (reg_wr) begin
      case (reg_addr)
        `RFGC_OFS_CTRL: begin
          fc_en_ff     <= reg_wdata[`RFGC_CTRL_FC_EN];
          fc_mode_ff   <= reg_wdata[`RFGC_CTRL_FC_MODE];
          gc_en_ff     <= reg_wdata[`RFGC_CTRL_GC_EN];
          freeze_en_ff <= reg_wdata[`RFGC_CTRL_FREEZE];
          mod_sel_ff   <= rfgc_mod_t'(reg_wdata[`RFGC_CTRL_MOD_LSB +: 2]);
        end
        `RFGC_OFS_FC_GAIN: begin
          slow_gain_ff <= reg_wdata[3:0];
          fast_gain_ff <= reg_wdata[7:4];
        end
        `RFGC_OFS_FC_PERIOD: period_ff <= reg_wdata[7:0];
        `RFGC_OFS_PWR_THR:   pwr_thr_ff <= reg_wdata[7:0];
        `RFGC_OFS_GC_HI:     hi_thr_ff <= reg_wdata[3:0];
        `RFGC_OFS_GC_LO: begin
          lo_thr0_ff <= reg_wdata[3:0];
          lo_thr1_ff <= reg_wdata[7:4];
        end
        `RFGC_OFS_GC_SEL:    lo_sel_ff <= reg_wdata[7:0];
        `RFGC_OFS_GC_TIME: begin
          meas_exp_ff <= reg_wdata[3:0];
          hold_val_ff <= reg_wdata[`RFGC_HOLD_LSB +: 6];
        end
        default: ;
      endcase
    end
  end

  // ---------------- Frequency offset compensation
  rfgc_fc_state_t       fc_state_ff;
  rfgc_fc_state_t       nxt_fc_state;
  logic [7:0]           fc_cnt_ff;
  logic signed [FW-1:0] fmin_ff;
  logic signed [FW-1:0] fmax_ff;
  logic signed [FW-1:0] est_ff;
  logic signed [FW-1:0] nmin;
  logic signed [FW-1:0] nmax;
  logic signed [FW:0]   center;
  logic signed [FW+1:0] err;
  logic signed [FW+1:0] corr;
  logic [3:0]           gain;
  logic                 fm_sel;
  logic                 fc_start;
  logic                 fc_stop;
  logic                 fc_run;
  logic                 fast_done;

  assign fm_sel   = (mod_sel_ff == MOD_2FSK) || (mod_sel_ff == MOD_4FSK);
  assign fc_stop  = !fc_en_ff || !fm_sel || !rx_active;
  assign fc_start = !fc_stop && (rssi_level > pwr_thr_ff);
  assign fc_run   = (fc_state_ff != FC_IDLE) && freq_valid;
  // Zero period hands the switch to sync detection
  assign fast_done = (period_ff == 8'h00) ? sync_det
                   : (freq_valid && (fc_cnt_ff == period_ff - 8'h01));

  always_comb begin
    nxt_fc_state = fc_state_ff;
    case (fc_state_ff)
      FC_IDLE: nxt_fc_state = fc_start ? FC_FAST : FC_IDLE;
      FC_FAST: nxt_fc_state = fc_stop ? FC_IDLE : (fast_done ? FC_SLOW : FC_FAST);
      FC_SLOW: nxt_fc_state = fc_stop ? FC_IDLE : FC_SLOW;
      default: nxt_fc_state = FC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_state_ff <= FC_IDLE;
    end else begin
      fc_state_ff <= nxt_fc_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_cnt_ff <= 8'h00;
    end else if (fc_state_ff != FC_FAST) begin
      fc_cnt_ff <= 8'h00;
    end else if (freq_valid) begin
      fc_cnt_ff <= fc_cnt_ff + 8'h01;
    end
  end

  // Extremes of the demodulated frequency since the loop started
  assign nmin   = (freq_sample < fmin_ff) ? freq_sample : fmin_ff;
  assign nmax   = (freq_sample > fmax_ff) ? freq_sample : fmax_ff;
  assign center = ((FW+1)'(nmin) + (FW+1)'(nmax)) >>> 1;
  assign err    = (FW+2)'(center) - (FW+2)'(est_ff);
  assign gain   = (fc_state_ff == FC_FAST) ? fast_gain_ff : slow_gain_ff;
  assign corr   = err >>> gain;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmin_ff <= {1'b0, {(FW-1){1'b1}}};
      fmax_ff <= {1'b1, {(FW-1){1'b0}}};
    end else if (fc_state_ff == FC_IDLE) begin
      fmin_ff <= {1'b0, {(FW-1){1'b1}}};
      fmax_ff <= {1'b1, {(FW-1){1'b0}}};
    end else if (freq_valid) begin
      fmin_ff <= nmin;
      fmax_ff <= nmax;
    end
  end

  // Estimate moves toward the midpoint by 2^-gain each sample
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      est_ff <= '0;
    end else if (fc_state_ff == FC_IDLE && fc_start) begin
      est_ff <= '0;
    end else if (fc_run) begin
      est_ff <= FW'(est_ff + corr);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slicer_offset <= '0;
      if2_tune      <= '0;
      fc_fast_mode  <= 1'b0;
    end else begin
      slicer_offset <= fc_mode_ff ? '0 : est_ff;
      if2_tune      <= fc_mode_ff ? est_ff : '0;
      fc_fast_mode  <= (nxt_fc_state == FC_FAST);
    end
  end

  // ---------------- Gain control loop
  rfgc_gc_state_t gc_state_ff;
  rfgc_gc_state_t nxt_gc_state;
  logic [MW-1:0]  gc_cnt_ff;
  logic [MW-1:0]  nxt_gc_cnt;
  logic [3:0]     step_ff;
  logic [3:0]     nxt_step;
  logic           below_ff;
  logic           nxt_below;
  logic           frozen_ff;
  logic [2:0]     lo_idx;
  logic [3:0]     lo_thr;
  logic [MW-1:0]  hold_cyc;
  logic [MW-1:0]  meas_cyc;
  logic           gc_run;
  logic           too_high;

  assign lo_idx   = (step_ff > 4'd7) ? 3'd7 : step_ff[2:0];
  assign lo_thr   = lo_sel_ff[lo_idx] ? lo_thr1_ff : lo_thr0_ff;
  assign hold_cyc = MW'(`RFGC_TICK_MULT * hold_val_ff);
  assign meas_cyc = MW'(`RFGC_TICK_MULT) << meas_exp_ff;
  assign gc_run   = gc_en_ff && rx_active && !frozen_ff;
  assign too_high = amp_valid && (amp_peak > hi_thr_ff);

  // Freeze on sync; the set wins over the end-of-reception clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frozen_ff <= 1'b0;
    end else if (freeze_en_ff && sync_det && gc_en_ff) begin
      frozen_ff <= 1'b1;
    end else if (!rx_active || !gc_en_ff) begin
      frozen_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_gc_state = gc_state_ff;
    nxt_gc_cnt   = gc_cnt_ff;
    nxt_step     = step_ff;
    nxt_below    = below_ff;
    case (gc_state_ff)
      GC_IDLE: if (gc_run) begin
        nxt_gc_state = GC_MEAS;
        nxt_gc_cnt   = meas_cyc;
        nxt_below    = 1'b1;
      end
      GC_HOLD: if (gc_cnt_ff <= MW'(1)) begin
        nxt_gc_state = GC_MEAS;
        nxt_gc_cnt   = meas_cyc;
        nxt_below    = 1'b1;
      end else begin
        nxt_gc_cnt = gc_cnt_ff - MW'(1);
      end
      GC_MEAS: begin
        if (too_high) begin
          // No measuring while too strong: step and hold at once
          if (step_ff < 4'(`RFGC_MAX_STEP)) begin
            nxt_step = step_ff + 4'd1;
          end
          nxt_gc_state = GC_HOLD;
          nxt_gc_cnt   = hold_cyc;
        end else begin
          if (amp_valid && (amp_peak >= lo_thr)) begin
            nxt_below = 1'b0;
          end
          if (gc_cnt_ff <= MW'(1)) begin
            if (nxt_below && (step_ff != 4'd0)) begin
              nxt_step     = step_ff - 4'd1;
              nxt_gc_state = GC_HOLD;
              nxt_gc_cnt   = hold_cyc;
            end else begin
              nxt_gc_cnt = meas_cyc;
              nxt_below  = 1'b1;
            end
          end else begin
            nxt_gc_cnt = gc_cnt_ff - MW'(1);
          end
        end
      end
      default: nxt_gc_state = GC_IDLE;
    endcase
    if (!gc_run) begin
      nxt_gc_state = GC_IDLE;
      nxt_step     = step_ff;
    end
    if (!rx_active || !gc_en_ff) begin
      nxt_step = 4'd0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gc_state_ff <= GC_IDLE;
      gc_cnt_ff   <= '0;
      below_ff    <= 1'b0;
    end else begin
      gc_state_ff <= nxt_gc_state;
      gc_cnt_ff   <= nxt_gc_cnt;
      below_ff    <= nxt_below;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_ff <= 4'd0;
    end else begin
      step_ff <= nxt_step;
    end
  end

  assign atten_step = step_ff;
  assign atten_db   = 6'(step_ff * `RFGC_STEP_DB);

  // ---------------- Register read port
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr)
      `RFGC_OFS_CTRL: begin
        nxt_rdata[`RFGC_CTRL_FC_EN]      = fc_en_ff;
        nxt_rdata[`RFGC_CTRL_FC_MODE]    = fc_mode_ff;
        nxt_rdata[`RFGC_CTRL_GC_EN]      = gc_en_ff;
        nxt_rdata[`RFGC_CTRL_FREEZE]     = freeze_en_ff;
        nxt_rdata[`RFGC_CTRL_MOD_LSB +: 2] = mod_sel_ff;
      end
      `RFGC_OFS_FC_GAIN:   nxt_rdata[7:0] = {fast_gain_ff, slow_gain_ff};
      `RFGC_OFS_FC_PERIOD: nxt_rdata[7:0] = period_ff;
      `RFGC_OFS_PWR_THR:   nxt_rdata[7:0] = pwr_thr_ff;
      `RFGC_OFS_GC_HI:     nxt_rdata[3:0] = hi_thr_ff;
      `RFGC_OFS_GC_LO:     nxt_rdata[7:0] = {lo_thr1_ff, lo_thr0_ff};
      `RFGC_OFS_GC_SEL:    nxt_rdata[7:0] = lo_sel_ff;
      `RFGC_OFS_GC_TIME: begin
        nxt_rdata[3:0]                 = meas_exp_ff;
        nxt_rdata[`RFGC_HOLD_LSB +: 6] = hold_val_ff;
      end
      `RFGC_OFS_FERR: nxt_rdata = 32'(est_ff);
      `RFGC_OFS_STATUS: begin
        nxt_rdata[3:0] = step_ff;
        nxt_rdata[4]   = (fc_state_ff == FC_FAST);
        nxt_rdata[5]   = (fc_state_ff == FC_SLOW);
        nxt_rdata[6]   = frozen_ff;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;

  // ---------------- Checks
  logic [MW-1:0] hold_len_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_len_ff <= '0;
    end else if (gc_state_ff == GC_HOLD) begin
      hold_len_ff <= hold_len_ff + MW'(1);
    end else begin
      hold_len_ff <= '0;
    end
  end

  fc_fm_only_a: assert property (!fm_sel |=> fc_state_ff == FC_IDLE)
    else $error("frequency loop active without FSK");
  fc_route_a: assert property ((!fc_mode_ff ##1 !fc_mode_ff)
    |-> if2_tune == '0 && slicer_offset == $past(est_ff))
    else $error("slicer mode drove second IF");
  fc_status_a: assert property (reg_rd && reg_addr == `RFGC_OFS_FERR
    |=> reg_rdata == 32'($past(est_ff))) else $error("error estimate read mismatch");
  fc_start_a: assert property (fc_state_ff == FC_IDLE && fc_start
    |=> fc_state_ff == FC_FAST) else $error("fast mode did not start");
  fc_sync_switch_a: assert property (fc_state_ff == FC_FAST && period_ff == 8'h00
    && sync_det && !fc_stop |=> fc_state_ff == FC_SLOW)
    else $error("sync did not switch to slow gain");
  fc_count_switch_a: assert property (fc_state_ff == FC_FAST && period_ff != 8'h00
    && !fc_stop && freq_valid && fc_cnt_ff < period_ff - 8'h01 |=> fc_state_ff == FC_FAST)
    else $error("fast period ended early");
  fc_disable_a: assert property (!fc_en_ff
    |=> fc_state_ff == FC_IDLE ##1 fc_state_ff == FC_IDLE || fc_en_ff)
    else $error("loop ran while disabled");
  gc_max_step_a: assert property (atten_step <= 4'(`RFGC_MAX_STEP)
    && atten_db == 6'(atten_step * `RFGC_STEP_DB)) else $error("attenuation beyond limit");
  gc_raise_a: assert property (gc_state_ff == GC_MEAS && gc_run && too_high
    && step_ff < 4'(`RFGC_MAX_STEP) |=> step_ff == $past(step_ff) + 4'd1
    && gc_state_ff == GC_HOLD) else $error("high amplitude did not raise attenuation");
  gc_lower_a: assert property ($past(gc_run) && gc_run && step_ff < $past(step_ff)
    |-> $past(gc_state_ff) == GC_MEAS && $past(gc_cnt_ff) <= MW'(1))
    else $error("attenuation lowered before measure end");
  gc_hold_len_a: assert property (gc_state_ff == GC_HOLD && nxt_gc_state == GC_MEAS
    |-> hold_len_ff + MW'(1) >= hold_cyc) else $error("hold time too short");
  gc_freeze_a: assert property (frozen_ff && rx_active && gc_en_ff
    |=> $stable(step_ff)) else $error("attenuation moved while frozen");
  gc_settled_a: assert property (gc_state_ff == GC_MEAS && gc_run && !too_high
    && !below_ff |=> $stable(step_ff)) else $error("attenuation changed within thresholds");
endmodule

// ---- common/rfgc_defs.svh ----
`ifndef RFGC_DEFS_SVH
`define RFGC_DEFS_SVH
// Function
// - Frequency compensation runs only for two- or four-level FSK/GFSK.
// - Track min and max demodulated frequency, derive offset correction.
// - Mode bit zero corrects at slicer, one retunes second IF.
// - Current frequency error estimate readable in a status register.
// - Start fast gain above power threshold, slow after fast period.
// - Fast and slow gains are four-bit log2 values, 0 to 15.
// - Fast period counts samples 0..255; zero switches on sync detect.
// - Enable bit turns frequency compensation on or off.
// - Attenuation moves in 6 dB steps up to 48 dB.
// - Peak amplitude compared against low and high thresholds.
// - Above high threshold, skip measuring, raise one step each hold.
// - Lower one step after whole measure interval below low threshold.
// - High threshold field 0..15, recommended 5.
// - Two low thresholds, 5 and 4, chosen per step by select field.
// - Measure interval is 12 clocks times two to exponent, default 2.
// - After each change wait 12 clocks times hold value, default 0x0C.
// - Gain control enable bit and freeze level on sync option.
// - Repeat steps until amplitude sits between thresholds, then hold.

`define RFGC_OFS_CTRL      8'h00
`define RFGC_OFS_FC_GAIN   8'h04
`define RFGC_OFS_FC_PERIOD 8'h08
`define RFGC_OFS_PWR_THR   8'h0C
`define RFGC_OFS_GC_HI     8'h10
`define RFGC_OFS_GC_LO     8'h14
`define RFGC_OFS_GC_SEL    8'h18
`define RFGC_OFS_GC_TIME   8'h1C
`define RFGC_OFS_FERR      8'h20
`define RFGC_OFS_STATUS    8'h24

`define RFGC_CTRL_FC_EN    0
`define RFGC_CTRL_FC_MODE  1
`define RFGC_CTRL_GC_EN    2
`define RFGC_CTRL_FREEZE   3
`define RFGC_CTRL_MOD_LSB  4
`define RFGC_HOLD_LSB      8

`define RFGC_RST_FAST_GAIN 4'h2
`define RFGC_RST_SLOW_GAIN 4'h5
`define RFGC_RST_PERIOD    8'h10
`define RFGC_RST_PWR_THR   8'h40
`define RFGC_RST_HI_THR    4'h5
`define RFGC_RST_LO_THR0   4'h5
`define RFGC_RST_LO_THR1   4'h4
`define RFGC_RST_LO_SEL    8'h10
`define RFGC_RST_MEAS_EXP  4'h2
`define RFGC_RST_HOLD      6'h0C

`define RFGC_TICK_MULT     12
`define RFGC_STEP_DB       6
`define RFGC_MAX_DB        48
`define RFGC_MAX_STEP      (`RFGC_MAX_DB / `RFGC_STEP_DB)
`endif

// ---- common/rfgc_pkg.sv ----
package rfgc_pkg;
  typedef enum logic [1:0] {
    MOD_2FSK,
    MOD_4FSK,
    MOD_ASK,
    MOD_OOK
  } rfgc_mod_t;

  typedef enum logic [1:0] {
    FC_IDLE,
    FC_FAST,
    FC_SLOW
  } rfgc_fc_state_t;

  typedef enum logic [1:0] {
    GC_IDLE,
    GC_HOLD,
    GC_MEAS
  } rfgc_gc_state_t;
endpackage

// ---- test/rfgc_far_model.sv ----
module rfgc_far_model #(
  parameter logic [15:0] DEV = 16'h0200
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               en,
  input  wire logic [3:0]         sig_level,
  input  wire logic signed [15:0] freq_offset,
  input  wire logic [3:0]         atten_step,
  output logic                    freq_valid,
  output logic signed [15:0]      freq_sample,
  output logic                    amp_valid,
  output logic [3:0]              amp_peak
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] phase_ff;
  logic       sign_ff;

  // Data lines invert every cycle between samples, so stale values match the last sample only on alternate cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff    <= 2'h0;
      sign_ff     <= 1'b0;
      freq_valid  <= 1'b0;
      amp_valid   <= 1'b0;
      freq_sample <= 16'sh0000;
      amp_peak    <= 4'h0;
    end else begin
      phase_ff   <= phase_ff + 2'h1;
      freq_valid <= en && (phase_ff == 2'h0);
      amp_valid  <= en && (phase_ff == 2'h2);
      if (en && phase_ff == 2'h0) begin
        sign_ff     <= ~sign_ff;
        freq_sample <= sign_ff ? freq_offset - $signed(DEV) : freq_offset + $signed(DEV);
      end else begin
        freq_sample <= ~freq_sample;
      end
      if (en && phase_ff == 2'h2) begin
        amp_peak <= (sig_level > atten_step) ? sig_level - atten_step : 4'h0;
      end else begin
        amp_peak <= ~amp_peak;
      end
    end
  end
endmodule

// ---- test/tb_rx_freq_gain_control.sv ----
`include "rfgc_defs.svh"

module tb_rx_freq_gain_control;
  timeunit 1ns;
  timeprecision 100ps;

  logic               core_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         reg_addr = 8'h00;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic               rx_active = 1'b0;
  logic               sync_det = 1'b0;
  logic [7:0]         rssi_level = 8'h00;
  logic               src_en = 1'b0;
  logic [3:0]         sig_level = 4'h0;
  logic signed [15:0] f_ofs = -16'sh0123;
  logic [31:0]        reg_rdata;
  logic [31:0]        rd_val;
  logic               freq_valid;
  logic               amp_valid;
  logic               fc_fast_mode;
  logic signed [15:0] freq_sample;
  logic signed [15:0] slicer_offset;
  logic signed [15:0] if2_tune;
  logic [3:0]         amp_peak;
  logic [3:0]         atten_step;
  logic [5:0]         atten_db;
  int                 err_total = 0;
  int                 samples_checked = 0;

  always #12.5 core_clk = ~core_clk;

  rfgc_core uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_active(rx_active), .sync_det(sync_det), .rssi_level(rssi_level),
    .freq_valid(freq_valid), .freq_sample(freq_sample), .amp_valid(amp_valid),
    .amp_peak(amp_peak), .slicer_offset(slicer_offset), .if2_tune(if2_tune),
    .atten_step(atten_step), .atten_db(atten_db), .fc_fast_mode(fc_fast_mode));

  rfgc_far_model link_side (.core_clk(core_clk), .rst_n(rst_n), .en(src_en),
    .sig_level(sig_level), .freq_offset(f_ofs), .atten_step(atten_step),
    .freq_valid(freq_valid), .freq_sample(freq_sample), .amp_valid(amp_valid),
    .amp_peak(amp_peak));

  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse_sync();
    @(posedge core_clk);
    sync_det <= 1'b1;
    @(posedge core_clk);
    sync_det <= 1'b0;
  endtask

  // Cycles until the attenuation step moves, bounded by lim
  task automatic wait_change(input int lim, output int n);
    logic [3:0] s;
    s = atten_step;
    n = 0;
    while (atten_step === s && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic wait_step(input logic [3:0] v, input int lim);
    int n;
    n = 0;
    while (atten_step !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic t_regs();
    logic [7:0]  ra [0:9] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
                              8'h24, 8'h30};
    logic [31:0] rv [0:9] = '{32'h25, 32'h10, 32'h40, 32'h5, 32'h45, 32'h10, 32'h0C02,
                              32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 10; i++) begin
      rd(ra[i]);
      chk_reg(rd_val, rv[i]);
    end
    wr(`RFGC_OFS_STATUS, 32'hFF);
    wr(8'h30, 32'hFF);
    rd(`RFGC_OFS_STATUS);
    chk_reg(rd_val, 32'h0);
    rd(8'h30);
    chk_reg(rd_val, 32'h0);
    wr(`RFGC_OFS_FC_GAIN, 32'hFF);
    rd(`RFGC_OFS_FC_GAIN);
    chk_reg(rd_val, 32'hFF);
    wr(`RFGC_OFS_FC_GAIN, 32'h00);
  endtask

  task automatic t_fc_modes();
    logic [31:0] cv [0:5] = '{32'h01, 32'h11, 32'h21, 32'h31, 32'h00, 32'h01};
    logic [7:0]  rv [0:5] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h40};
    logic        ev [0:5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      wr(`RFGC_OFS_CTRL, 32'h0);
      rssi_level <= rv[i];
      wr(`RFGC_OFS_CTRL, cv[i]);
      cyc(2);
      chk_sig(16'(fc_fast_mode), 16'(ev[i]));
    end
  endtask

  task automatic t_fc_track();
    wr(`RFGC_OFS_FC_PERIOD, 32'h4);
    wr(`RFGC_OFS_CTRL, 32'h0);
    rssi_level <= 8'h80;
    wr(`RFGC_OFS_CTRL, 32'h01);
    cyc(2);
    chk_sig(16'(fc_fast_mode), 16'h1);
    cyc(40);
    chk_sig(16'(fc_fast_mode), 16'h0);
    rd(`RFGC_OFS_STATUS);
    chk_reg(rd_val, 32'h20);
    rd(`RFGC_OFS_FERR);
    chk_reg(rd_val, 32'hFFFFFEDD);
    chk_sig(slicer_offset, f_ofs);
    chk_sig(if2_tune, 16'h0);
    wr(`RFGC_OFS_CTRL, 32'h03);
    cyc(3);
    chk_sig(if2_tune, f_ofs);
    chk_sig(slicer_offset, 16'h0);
    wr(`RFGC_OFS_FC_PERIOD, 32'h0);
    wr(`RFGC_OFS_CTRL, 32'h0);
    wr(`RFGC_OFS_CTRL, 32'h01);
    cyc(80);
    chk_sig(16'(fc_fast_mode), 16'h1);
    pulse_sync();
    cyc(3);
    chk_sig(16'(fc_fast_mode), 16'h0);
    wr(`RFGC_OFS_CTRL, 32'h0);
  endtask

  task automatic t_gc_up();
    int n;
    wr(`RFGC_OFS_GC_TIME, 32'h0104);
    sig_level <= 4'hF;
    wr(`RFGC_OFS_CTRL, 32'h04);
    wait_change(40, n);
    wait_change(40, n);
    chk_sig(16'(n >= 12 && n <= 18), 16'h1);
    wait_step(4'h8, 200);
    cyc(60);
    chk_sig(16'(atten_step), 16'h8);
    chk_sig(16'(atten_db), 16'd48);
  endtask

  task automatic t_gc_down();
    int         n;
    logic [3:0] s;
    wr(`RFGC_OFS_GC_TIME, 32'h0100);
    sig_level <= 4'h0;
    wait_change(300, n);
    s = atten_step;
    cyc(18);
    chk_sig(16'(atten_step), 16'(s));
    wait_change(20, n);
    chk_sig(16'(atten_step), 16'(s - 4'h1));
    wait_step(4'h0, 300);
    cyc(60);
    chk_sig(16'(atten_step), 16'h0);
    chk_sig(16'(atten_db), 16'h0);
  endtask

  task automatic t_gc_settle();
    int n;
    wr(`RFGC_OFS_GC_LO, 32'h46);
    sig_level <= 4'h9;
    wr(`RFGC_OFS_CTRL, 32'h04);
    cyc(300);
    chk_sig(16'(atten_step), 16'h4);
    wr(`RFGC_OFS_GC_SEL, 32'h00);
    wait_change(60, n);
    chk_sig(16'(atten_step), 16'h3);
    wr(`RFGC_OFS_CTRL, 32'h00);
    cyc(2);
    chk_sig(16'(atten_step), 16'h0);
    wr(`RFGC_OFS_GC_LO, 32'h45);
    wr(`RFGC_OFS_GC_SEL, 32'h10);
  endtask

  task automatic t_gc_freeze();
    logic [3:0] s;
    sig_level <= 4'hF;
    wr(`RFGC_OFS_CTRL, 32'h0C);
    wait_step(4'h2, 100);
    pulse_sync();
    cyc(2);
    s = atten_step;
    cyc(100);
    chk_sig(16'(atten_step), 16'(s));
    rd(`RFGC_OFS_STATUS);
    chk_reg(rd_val, {25'h0, 1'b1, 2'b00, s});
    @(posedge core_clk);
    rx_active <= 1'b0;
    cyc(3);
    chk_sig(16'(atten_step), 16'h0);
    @(posedge core_clk);
    rx_active <= 1'b1;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rst_n     <= 1'b1;
    rx_active <= 1'b1;
    src_en    <= 1'b1;
    t_regs();
    t_fc_modes();
    t_fc_track();
    t_gc_up();
    t_gc_down();
    t_gc_settle();
    t_gc_freeze();
    wrap_up();
  end
endmodule
